/* rtl/watchdog_timer_unit.sv */
`timescale 1ns/1ps
`default_nettype none
//Behaviour
//R1 - After any reset the timer runs, longest timeout, system-reset action.
//R2 - Only one configuration write accepted after each reset.
//R3 - Configuration needs keys 3333h then CCCCh, then the configuration word.
//R4 - Non-register accesses between the two keys are tolerated.
//R5 - Writing AAAAh then 5555h restarts the count.
//R6 - The running count is never readable.
//R7 - Longest timeout is about 1.67 s at 40 MHz.
//R8 - Expiry gives a non-maskable interrupt or a system reset, as configured.
//R9 - Interrupt-mode expiry sets the timeout interrupt flag, bit 12.
//R10 - Service routine clears that flag with unlock plus a configuration word.
//R11 - Expiry while the flag is set gives a system reset instead.
//R12 - Watchdog-caused reset sets the watchdog reset flag, bit 13.
//R13 - Any read or write of the control register clears the reset flag.
//R14 - Watchdog reset does not re-sample the configuration pins.
//R15 - Otherwise a watchdog reset acts as a normal system reset.
//R16 - A register access breaking a keyed sequence abandons it.
//R17 - Power-on reset clears the interrupt flag; software can read it.
module watchdog_timer_unit
    import wdt_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_MAX_CYCLES
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_reg_sel,
    input  wire logic             i_reg_wr,
    input  wire logic             i_reg_rd,
    input  wire logic [15:0]      i_reg_wdata,
    input  wire logic [PIN_W-1:0] i_cfg_pins,
    output logic      [15:0]      o_reg_rdata,
    output logic                  o_nmi,
    output logic                  o_sys_rst,
    output logic      [PIN_W-1:0] o_cfg_pins
);
    logic [CNT_W-1:0] cnt_reg;
    logic [15:0]      cfg_reg;
    logic             cfg_done_reg;
    logic             nmi_flag_reg;
    logic             rst_flag_reg;
    logic [15:0]      rdata_reg;
    logic             nmi_reg;
    logic             sys_rst_reg;
    logic [PIN_W-1:0] pins_reg;
    logic             pins_taken_reg;
    logic             access;
    logic             expire;
    logic             nmi_evt;
    logic             wdt_rst_evt;

    wdt_seq_if sq ();

    wdt_key_sequencer u_seq (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .bus    (sq.seq)
    );

    function automatic logic [CNT_W-1:0] limit_of(input logic [2:0] sel);
        logic [31:0] full;
        full     = 32'(TIMEOUT_CYCLES) >> (SEL_MAX - sel);
        limit_of = CNT_W'(full - 32'h1);
    endfunction

    assign access      = i_reg_sel && (i_reg_wr || i_reg_rd);
    assign sq.wr       = i_reg_sel && i_reg_wr;
    assign sq.rd       = i_reg_sel && i_reg_rd;
    assign sq.wdata    = i_reg_wdata;
    assign sq.soft_rst = wdt_rst_evt;

    // At or past the limit, so a shorter select taken mid-count still expires
    assign expire      = cfg_reg[EN_BIT] && (cnt_reg >= limit_of(cfg_reg[SEL_MSB:0])); // see R7
    assign nmi_evt     = expire && cfg_reg[MODE_BIT] && !nmi_flag_reg; // see R8
    assign wdt_rst_evt = expire && (!cfg_reg[MODE_BIT] || nmi_flag_reg); // see R8, see R11

    // Count restarts on expiry, on the restart pair and while disabled
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg <= '0;
        end else if (expire || sq.restart_stb || !cfg_reg[EN_BIT]) begin
            cnt_reg <= '0; // see R5
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // The watchdog reset reloads the same defaults as a pin reset
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg_reg      <= CFG_RESET; // see R1
            cfg_done_reg <= 1'b0;
        end else if (wdt_rst_evt) begin
            cfg_reg      <= CFG_RESET; // see R1, see R15
            cfg_done_reg <= 1'b0;
        end else if (sq.cfg_stb && !cfg_done_reg) begin
            cfg_reg      <= sq.cfg_word & CFG_WR_MASK; // see R2
            cfg_done_reg <= 1'b1;
        end
    end

    // Later keyed writes may still clear the flag, otherwise the handler could never rearm
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            nmi_flag_reg <= 1'b0; // see R17
        end else if (wdt_rst_evt) begin
            nmi_flag_reg <= 1'b0; // see R15
        end else if (nmi_evt) begin
            nmi_flag_reg <= 1'b1; // see R9
        end else if (sq.cfg_stb) begin
            nmi_flag_reg <= sq.cfg_word[NMIF_BIT]; // see R10
        end
    end

    // Set wins over the clear by a same-cycle access
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_flag_reg <= 1'b0;
        end else if (wdt_rst_evt) begin
            rst_flag_reg <= 1'b1; // see R12
        end else if (access) begin
            rst_flag_reg <= 1'b0; // see R13
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            nmi_reg     <= 1'b0;
            sys_rst_reg <= 1'b0;
        end else begin
            nmi_reg     <= nmi_evt; // see R8
            sys_rst_reg <= wdt_rst_evt; // see R8, see R12
        end
    end

    // Count bits never reach the read path
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_reg <= ZERO_WORD;
        end else if (wdt_rst_evt) begin
            rdata_reg <= ZERO_WORD; // see R15
        end else if (sq.rd) begin
            rdata_reg <= (cfg_reg & CFG_WR_MASK) | (16'(rst_flag_reg) << RSTF_BIT)
                         | (16'(nmi_flag_reg) << NMIF_BIT); // see R6, see R17
        end
    end

    // Pins are caught once after pin reset; the watchdog reset leaves them alone
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pins_reg       <= '0;
            pins_taken_reg <= 1'b0;
        end else if (!pins_taken_reg) begin
            pins_reg       <= i_cfg_pins; // see R14
            pins_taken_reg <= 1'b1;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_nmi       = nmi_reg;
    assign o_sys_rst   = sys_rst_reg;
    assign o_cfg_pins  = pins_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_second_timeout;
        expire && cfg_reg[MODE_BIT] && nmi_flag_reg;
    endsequence

    wdt_reset_defaults_a: assert property (o_sys_rst |-> cfg_reg == CFG_RESET // see R1
        && !cfg_done_reg && rst_flag_reg && cnt_reg == '0)
        else $error("watchdog reset did not reload defaults");
    single_config_a: assert property ((cfg_done_reg && !wdt_rst_evt) |=> // see R2
        cfg_reg == $past(cfg_reg))
        else $error("second configuration accepted");
    restart_clears_a: assert property ((sq.restart_stb && cfg_reg[EN_BIT]) |=> cnt_reg == '0) // see R5
        else $error("restart pair did not clear count");
    read_hides_count_a: assert property (sq.rd |=> // see R6
        o_reg_rdata[NMIF_BIT-1:SEL_MSB+1] == '0)
        else $error("count bits visible on read");
    nmi_sets_flag_a: assert property (nmi_evt |=> o_nmi && nmi_flag_reg && !o_sys_rst) // see R9
        else $error("interrupt expiry did not set flag");
    second_timeout_a: assert property (s_second_timeout |=> o_sys_rst && !o_nmi) // see R11
        else $error("second timeout did not reset");
    access_clears_rst_a: assert property ((access && !wdt_rst_evt) |=> !rst_flag_reg) // see R13
        else $error("access did not clear reset flag");
    pins_kept_a: assert property (o_sys_rst |-> $stable(o_cfg_pins) && pins_taken_reg) // see R14
        else $error("pins re-sampled on watchdog reset");

    sequence s_reset_timeout;
        expire && !cfg_reg[MODE_BIT];
    endsequence

    sequence s_first_config;
        sq.cfg_stb && !cfg_done_reg && !wdt_rst_evt;
    endsequence

    reset_action_a: assert property (s_reset_timeout |=> o_sys_rst && !o_nmi) // see R8
        else $error("reset-mode expiry did not reset");
    one_action_a: assert property (!(o_nmi && o_sys_rst)) // see R8
        else $error("interrupt and reset raised together");
    expire_restarts_a: assert property (expire |=> cnt_reg == '0) // see R7
        else $error("count not restarted on expiry");
    disabled_hold_a: assert property (!cfg_reg[EN_BIT] |=> cnt_reg == '0 && !o_nmi) // see R8
        else $error("disabled timer still counting");
    rst_flag_set_a: assert property (wdt_rst_evt |=> rst_flag_reg && o_sys_rst) // see R12
        else $error("watchdog reset flag not set");
    first_config_a: assert property (s_first_config |=> cfg_done_reg // see R2
        && cfg_reg == ($past(sq.cfg_word) & CFG_WR_MASK))
        else $error("first configuration not taken");
    flag_write_a: assert property ((sq.cfg_stb && !nmi_evt && !wdt_rst_evt) |=> // see R10
        nmi_flag_reg == $past(sq.cfg_word[NMIF_BIT]))
        else $error("keyed write did not update interrupt flag");
    read_flags_a: assert property ((sq.rd && !wdt_rst_evt) |=> // see R17
        o_reg_rdata[NMIF_BIT] == $past(nmi_flag_reg)
        && o_reg_rdata[RSTF_BIT] == $past(rst_flag_reg))
        else $error("flags not shown on read");
    // Read data must stand until the next read or a watchdog reset
    rdata_hold_a: assert property ((!sq.rd && !wdt_rst_evt) |=> $stable(o_reg_rdata)) // see R17
        else $error("read data changed without a read");
    pins_hold_a: assert property (pins_taken_reg |=> o_cfg_pins == $past(o_cfg_pins)) // see R14
        else $error("configuration pins changed after capture");
endmodule
`default_nettype wire

/* rtl/wdt_pkg.sv */
`default_nettype none
package wdt_pkg;
    localparam int unsigned CLK_HZ             = 40_000_000;
    localparam int unsigned TIMEOUT_MAX_MS     = 1670;
    // Longest timeout, rounded down to whole cycles
    localparam int unsigned TIMEOUT_MAX_CYCLES = TIMEOUT_MAX_MS * (CLK_HZ / 1000);
    localparam int          CNT_W              = 27;
    localparam int          PIN_W              = 8;

    localparam logic [15:0] KEY_UNLOCK_1  = 16'h3333;
    localparam logic [15:0] KEY_UNLOCK_2  = 16'hCCCC;
    localparam logic [15:0] KEY_RESTART_1 = 16'hAAAA;
    localparam logic [15:0] KEY_RESTART_2 = 16'h5555;

    localparam int          EN_BIT   = 15;
    localparam int          MODE_BIT = 14;
    localparam int          RSTF_BIT = 13;
    localparam int          NMIF_BIT = 12;
    localparam int          SEL_MSB  = 2;
    localparam logic [2:0]  SEL_MAX  = 3'h7;

    // Enabled, reset action, longest timeout
    localparam logic [15:0] CFG_RESET   = 16'h8007;
    localparam logic [15:0] CFG_WR_MASK = 16'hC007;
    localparam logic [15:0] ZERO_WORD   = 16'h0000;

    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_UNLOCK  = 2'b01,
        SEQ_CONFIG  = 2'b10,
        SEQ_RESTART = 2'b11
    } seq_state_e;
endpackage
`default_nettype wire

/* rtl/wdt_seq_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface wdt_seq_if;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
    logic        soft_rst;
    logic        cfg_stb;
    logic [15:0] cfg_word;
    logic        restart_stb;

    modport seq (input wr, rd, wdata, soft_rst, output cfg_stb, cfg_word, restart_stb);
    modport ctl (output wr, rd, wdata, soft_rst, input cfg_stb, cfg_word, restart_stb);
endinterface
`default_nettype wire

/* rtl/wdt_key_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_key_sequencer
    import wdt_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_nrst,
    wdt_seq_if.seq     bus
);
    seq_state_e state_reg;

    function automatic logic key_hit(input logic [15:0] data, input logic [15:0] key);
        key_hit = (data == key);
    endfunction

    // Only accesses to the control register reach here, so other traffic never breaks a sequence
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= SEQ_IDLE;
        end else if (bus.soft_rst) begin
            state_reg <= SEQ_IDLE;
        end else if (bus.wr || bus.rd) begin // see R4
            case (state_reg)
                SEQ_IDLE: begin
                    if (bus.wr && key_hit(bus.wdata, KEY_UNLOCK_1)) begin
                        state_reg <= SEQ_UNLOCK; // see R3
                    end else if (bus.wr && key_hit(bus.wdata, KEY_RESTART_1)) begin
                        state_reg <= SEQ_RESTART; // see R5
                    end else begin
                        state_reg <= SEQ_IDLE;
                    end
                end
                SEQ_UNLOCK: begin
                    if (bus.wr && key_hit(bus.wdata, KEY_UNLOCK_2)) begin
                        state_reg <= SEQ_CONFIG;
                    end else begin
                        state_reg <= SEQ_IDLE; // see R16
                    end
                end
                default: begin
                    state_reg <= SEQ_IDLE; // see R16
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus.cfg_stb     <= 1'b0;
            bus.restart_stb <= 1'b0;
            bus.cfg_word    <= ZERO_WORD;
        end else begin
            bus.cfg_stb     <= !bus.soft_rst && bus.wr && (state_reg == SEQ_CONFIG); // see R3
            bus.restart_stb <= !bus.soft_rst && bus.wr && (state_reg == SEQ_RESTART)
                               && key_hit(bus.wdata, KEY_RESTART_2); // see R5
            if (bus.wr && (state_reg == SEQ_CONFIG)) begin
                bus.cfg_word <= bus.wdata;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_unlocked;
        state_reg == SEQ_CONFIG && bus.wr && !bus.soft_rst;
    endsequence

    sequence s_restart_pair;
        state_reg == SEQ_RESTART && bus.wr && bus.wdata == KEY_RESTART_2 && !bus.soft_rst;
    endsequence

    config_after_keys_a: assert property (s_unlocked |=> bus.cfg_stb && state_reg == SEQ_IDLE) // see R3
        else $error("config word after keys not strobed");
    restart_pair_a: assert property (s_restart_pair |=> bus.restart_stb) // see R5
        else $error("restart pair not strobed");
    break_abandons_a: assert property ((state_reg == SEQ_UNLOCK && (bus.rd ||
        (bus.wr && bus.wdata != KEY_UNLOCK_2))) |=> state_reg == SEQ_IDLE) // see R16
        else $error("broken unlock sequence kept");
    no_stray_config_a: assert property (bus.cfg_stb |-> $past(state_reg) == SEQ_CONFIG) // see R3
        else $error("config strobe without keys");
endmodule
`default_nettype wire

/* testbench/watchdog_timer_unit_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_unit_bench
    import wdt_pkg::*;
;

    logic             i_clk;
    logic             i_nrst;
    logic             i_reg_sel;
    logic             i_reg_wr;
    logic             i_reg_rd;
    logic [15:0]      i_reg_wdata;
    logic [PIN_W-1:0] i_cfg_pins;
    logic [15:0]      o_reg_rdata;
    logic             o_nmi;
    logic             o_sys_rst;
    logic [PIN_W-1:0] o_cfg_pins;
    int               fails;
    int               tests_run;

    // Short limit keeps each expiry near 64 cycles with the longest select
    watchdog_timer_unit #(.TIMEOUT_CYCLES(64)) dut (
        .i_clk       (i_clk),
        .i_nrst      (i_nrst),
        .i_reg_sel   (i_reg_sel),
        .i_reg_wr    (i_reg_wr),
        .i_reg_rd    (i_reg_rd),
        .i_reg_wdata (i_reg_wdata),
        .i_cfg_pins  (i_cfg_pins),
        .o_reg_rdata (o_reg_rdata),
        .o_nmi       (o_nmi),
        .o_sys_rst   (o_sys_rst),
        .o_cfg_pins  (o_cfg_pins)
    );

    initial i_clk = 1'b0;
    always #12.5 i_clk = ~i_clk;

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] d);
        @(posedge i_clk);
        i_reg_sel   <= 1'b1;
        i_reg_wr    <= 1'b1;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_sel <= 1'b0;
        i_reg_wr  <= 1'b0;
    endtask

    // Data is registered on the read edge itself; sample one edge after it
    task automatic rd(input logic [15:0] exp);
        @(posedge i_clk);
        i_reg_sel <= 1'b1;
        i_reg_rd  <= 1'b1;
        @(posedge i_clk);
        i_reg_sel <= 1'b0;
        i_reg_rd  <= 1'b0;
        @(posedge i_clk);
        #1;
        chk("control read", exp, o_reg_rdata);
    endtask

    // Writes to other devices keep select low and must leave any sequence alone
    task automatic other_wr(input logic [15:0] d);
        @(posedge i_clk);
        i_reg_wr    <= 1'b1;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask

    task automatic restart(input int gap);
        wr(KEY_RESTART_1);
        repeat (gap) other_wr(KEY_UNLOCK_1);
        wr(KEY_RESTART_2);
    endtask

    // Waits for an expiry pulse and checks its kind, its delay and its width
    task automatic wait_evt(input logic want_nmi, input int lo, input int hi);
        int n;
        n = 0;
        while (n < 200 && o_nmi !== 1'b1 && o_sys_rst !== 1'b1) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("event is nmi", {15'h0000, want_nmi}, {15'h0000, o_nmi});
        chk("event in window", 16'h0001, {15'h0000, (n >= lo && n <= hi)});
        @(posedge i_clk);
        #1;
        chk("pulse width", 16'h0000, {14'h0000, o_nmi, o_sys_rst});
    endtask

    task automatic power_reset();
        @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        #1;
    endtask

    task automatic conclude();
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #(25ns * 4000);
        fails++;
        conclude();
    end

    initial begin
        fails       = 0;
        tests_run   = 0;
        i_nrst      = 1'b0;
        i_reg_sel   = 1'b0;
        i_reg_wr    = 1'b0;
        i_reg_rd    = 1'b0;
        i_reg_wdata = 16'h0000;
        i_cfg_pins  = 8'hA5;
        power_reset();
        chk("pins", 16'h00A5, {8'h00, o_cfg_pins});
        rd(16'h8007);
        @(posedge i_clk);
        i_cfg_pins <= 8'h3C;
        wait_evt(1'b0, 50, 70);
        chk("pins kept", 16'h00A5, {8'h00, o_cfg_pins});
        rd(16'hA007);
        rd(16'h8007);
        // Keep-alive: a missed restart would set the reset flag
        restart(3);
        repeat (40) @(posedge i_clk);
        restart(0);
        repeat (40) @(posedge i_clk);
        rd(16'h8007);
        // A read between the restart keys must void the restart
        restart(0);
        repeat (30) @(posedge i_clk);
        wr(KEY_RESTART_1);
        rd(16'h8007);
        wr(KEY_RESTART_2);
        wait_evt(1'b0, 15, 40);
        rd(16'hA007);
        restart(0);
        wr(KEY_UNLOCK_1);
        rd(16'h8007);
        wr(KEY_UNLOCK_2);
        wr(16'h0007);
        rd(16'h8007);
        wr(KEY_UNLOCK_1);
        repeat (3) other_wr(KEY_RESTART_1);
        wr(KEY_UNLOCK_2);
        wr(16'hC007);
        rd(16'hC007);
        restart(0);
        wait_evt(1'b1, 50, 70);
        rd(16'hD007);
        wr(KEY_UNLOCK_1);
        wr(KEY_UNLOCK_2);
        wr(16'h0007);
        rd(16'hC007);
        wait_evt(1'b1, 40, 70);
        rd(16'hD007);
        wait_evt(1'b0, 45, 70);
        rd(16'hA007);
        // Leave the interrupt flag set so that power-on reset must clear it
        wr(KEY_UNLOCK_1);
        wr(KEY_UNLOCK_2);
        wr(16'hC007);
        wait_evt(1'b1, 40, 70);
        power_reset();
        chk("pins resampled", 16'h003C, {8'h00, o_cfg_pins});
        rd(16'h8007);
        // A shorter select taken late in the count must expire at once
        repeat (40) @(posedge i_clk);
        wr(KEY_UNLOCK_1);
        wr(KEY_UNLOCK_2);
        wr(16'h8006);
        wait_evt(1'b0, 1, 3);
        wr(KEY_UNLOCK_1);
        wr(KEY_UNLOCK_2);
        wr(16'h8006);
        restart(0);
        wait_evt(1'b0, 25, 40);
        wr(ZERO_WORD);
        rd(16'h8007);
        conclude();
    end
endmodule
`default_nettype wire
